// >>> src/ccr_core.v
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "ccr_map.vh"

module ccr_core
(
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    input wire cpu_reset,
    // Register bus
    input wire [5:0] bus_addr,
    input wire [3:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [3:0] bus_rdata,
    // Operation
    input wire op_valid,
    input wire [3:0] op_code,
    input wire [3:0] alu_result,
    input wire alu_carry,
    input wire test_result,
    input wire [13:0] jump_target,
    input wire clear_reinit,
    input wire [13:0] pop_ip,
    input wire pop_ovf,
    input wire pop_cond,
    input wire [10:0] irq_event,
    // Frame push
    output reg push_strobe,
    output reg [9:0] push_addr,
    output reg [13:0] push_ip,
    output reg push_ovf,
    output reg push_cond,
    // Core state
    output reg fetch_en,
    output reg [13:0] instruction_pointer,
    output wire [9:0] frame_pointer,
    output wire overflow_bit,
    output wire condition_bit,
    output reg [3:0] acc,
    output reg [3:0] breg,
    output reg [1:0] page,
    output reg [3:0] col,
    output reg [3:0] row,
    output reg [15:0] d_line_sel,
    // Peripheral setup
    output wire global_irq_gate,
    output wire [10:0] irq_mask_bits,
    output reg [10:0] irq_req_flags,
    output wire [3:0] port_out_latch,
    output wire [3:0] port_dir_ctrl,
    output wire [3:0] edge_pick_1,
    output wire [3:0] edge_pick_2
);

    localparam BANK_N = 16;
    localparam [63:0] BANK_RST = `CCR_BANK_RST;
    localparam [63:0] BANK_WMASK = `CCR_BANK_WMASK;

    reg [3:0] col_extra_reg;
    reg [3:0] row_extra_reg;
    reg [3:0] bank [0:BANK_N-1];
    reg serial_cfg_b_low;
    reg serial_cfg_b_high;
    reg [10:0] prescaler_sys;
    reg [7:0] prescaler_w;
    reg [31:0] timer_flat;
    reg [13:0] next_ip;
    reg [3:0] next_acc;
    reg [3:0] rd_value;
    wire soft_reset;
    wire op_push;
    wire op_pop;
    wire op_taken_branch;
    wire [3:0] flags_rd;

    assign soft_reset = cpu_reset;
    assign op_taken_branch = condition_bit;
    assign op_push = op_valid && ((op_code == `CCR_OP_CALL && op_taken_branch)
                     || op_code == `CCR_OP_IRQ_ENTRY);
    assign op_pop = op_valid && (op_code == `CCR_OP_PLAIN_RET
                    || op_code == `CCR_OP_IRQ_RET);
    assign flags_rd = {2'b00, condition_bit, overflow_bit};

    // Flag unit
    ccr_flags u_flags
    (
        .mclk(mclk),
        .reset_n(reset_n),
        .soft_reset(soft_reset),
        .op_valid(op_valid),
        .op_code(op_code),
        .alu_carry(alu_carry),
        .test_result(test_result),
        .acc_msb(acc[3]),
        .acc_lsb(acc[0]),
        .pop_ovf(pop_ovf),
        .pop_cond(pop_cond),
        .wr_flags(bus_wr && bus_addr == `CCR_A_FLAGS && !op_valid),
        .wr_value(bus_wdata[1:0]),
        .overflow_bit(overflow_bit),
        .condition_bit(condition_bit)
    );

    // Frame pointer unit
    ccr_frame u_frame
    (
        .mclk(mclk),
        .reset_n(reset_n),
        .soft_reset(soft_reset),
        .push(op_push),
        .pop(op_pop),
        .reinit(op_valid && op_code == `CCR_OP_BIT_CLEAR && clear_reinit),
        .frame_pointer(frame_pointer)
    );

    // Instruction pointer next value
    always @*
    begin
        next_ip = instruction_pointer + 14'h0001;
        if (op_valid)
        begin
            case (op_code)
                `CCR_OP_JUMP, `CCR_OP_LJUMP, `CCR_OP_CALL:
                    if (op_taken_branch)
                        next_ip = jump_target;
                `CCR_OP_IRQ_ENTRY:
                    next_ip = jump_target;
                `CCR_OP_PLAIN_RET, `CCR_OP_IRQ_RET:
                    next_ip = pop_ip;
                default:
                    next_ip = instruction_pointer + 14'h0001;
            endcase
        end
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            instruction_pointer <= `CCR_IP_RST;
            fetch_en <= 1'b0;
        end
        else if (soft_reset)
        begin
            instruction_pointer <= `CCR_IP_RST;
            fetch_en <= 1'b0;
        end
        else
        begin
            fetch_en <= 1'b1;
            if (op_valid)
                instruction_pointer <= next_ip;
        end
    end

    // Frame push data
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            push_strobe <= 1'b0;
            push_addr <= `CCR_FP_RST;
            push_ip <= 14'h0000;
            push_ovf <= 1'b0;
            push_cond <= 1'b0;
        end
        else
        begin
            push_strobe <= op_push && !soft_reset;
            if (op_push)
            begin
                push_addr <= frame_pointer;
                push_ip <= instruction_pointer + 14'h0001;
                push_ovf <= overflow_bit;
                push_cond <= condition_bit;
            end
        end
    end

    // Accumulator next value
    always @*
    begin
        next_acc = acc;
        if (op_valid)
        begin
            case (op_code)
                `CCR_OP_ARITH:
                    next_acc = alu_result;
                `CCR_OP_SHL:
                    next_acc = {acc[2:0], overflow_bit};
                `CCR_OP_SHR:
                    next_acc = {overflow_bit, acc[3:1]};
                default:
                    next_acc = acc;
            endcase
        end
        else if (bus_wr && bus_addr == `CCR_A_ACC)
            next_acc = bus_wdata;
    end

    // Working and address registers
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc <= 4'h0;
            breg <= 4'h0;
            page <= 2'h0;
            col <= 4'h0;
            row <= 4'h0;
            col_extra_reg <= 4'h0;
            row_extra_reg <= 4'h0;
        end
        else
        begin
            acc <= next_acc;
            if (op_valid && op_code == `CCR_OP_EXCHANGE)
            begin
                col <= col_extra_reg;
                col_extra_reg <= col;
                row <= row_extra_reg;
                row_extra_reg <= row;
            end
            else if (bus_wr && !op_valid)
            begin
                case (bus_addr)
                    `CCR_A_BREG: breg <= bus_wdata;
                    `CCR_A_PAGE: page <= bus_wdata[1:0];
                    `CCR_A_COL: col <= bus_wdata;
                    `CCR_A_ROW: row <= bus_wdata;
                    `CCR_A_COL_X: col_extra_reg <= bus_wdata;
                    `CCR_A_ROW_X: row_extra_reg <= bus_wdata;
                    default: breg <= breg;
                endcase
            end
        end
    end

    // D port line select follows the row register
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            d_line_sel <= 16'h0001;
        else
            d_line_sel <= 16'h0001 << row;
    end

    // Setup bank with per-entry reset values and writable bits
    genvar gi;
    generate
        for (gi = 0; gi < BANK_N; gi = gi + 1)
        begin : g_bank
            always @(posedge mclk or negedge reset_n)
            begin
                if (!reset_n)
                    bank[gi] <= BANK_RST[4*gi+3:4*gi];
                else if (soft_reset)
                    bank[gi] <= BANK_RST[4*gi+3:4*gi];
                else if (bus_wr && bus_addr == `CCR_A_BANK0 + gi)
                    bank[gi] <= bus_wdata & BANK_WMASK[4*gi+3:4*gi];
            end
        end
    endgenerate

    assign global_irq_gate = bank[0][0];
    assign irq_mask_bits = {bank[3][2:0], bank[2], bank[1]};
    assign port_out_latch = bank[4];
    assign port_dir_ctrl = bank[5];
    assign edge_pick_1 = bank[6];
    assign edge_pick_2 = bank[7];

    // Interrupt requests: event wins over a software clear
    generate
        for (gi = 0; gi < 11; gi = gi + 1)
        begin : g_irq
            always @(posedge mclk or negedge reset_n)
            begin
                if (!reset_n)
                    irq_req_flags[gi] <= 1'b0;
                else if (soft_reset)
                    irq_req_flags[gi] <= 1'b0;
                else if (irq_event[gi])
                    irq_req_flags[gi] <= 1'b1;
                else if (bus_wr && bus_addr == `CCR_A_IRQ0 + gi / 4 && !bus_wdata[gi % 4])
                    irq_req_flags[gi] <= 1'b0;
            end
        end
    endgenerate

    // Serial mode B: only the low bit has a reset value
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            serial_cfg_b_low <= `CCR_SERB_LOW_RST;
        else if (soft_reset)
            serial_cfg_b_low <= `CCR_SERB_LOW_RST;
        else if (bus_wr && bus_addr == `CCR_A_SERB)
            serial_cfg_b_low <= bus_wdata[0];
    end

    always @(posedge mclk)
    begin
        if (bus_wr && bus_addr == `CCR_A_SERB)
            serial_cfg_b_high <= bus_wdata[1];
    end

    // Prescalers and bus-written timer registers
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prescaler_sys <= 11'h000;
            prescaler_w <= 8'h00;
        end
        else if (soft_reset)
        begin
            prescaler_sys <= 11'h000;
            prescaler_w <= 8'h00;
        end
        else
        begin
            prescaler_sys <= prescaler_sys + 11'h001;
            prescaler_w <= prescaler_w + 8'h01;
        end
    end

    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_tmr
            always @(posedge mclk or negedge reset_n)
            begin
                if (!reset_n)
                    timer_flat[4*gi+3:4*gi] <= 4'h0;
                else if (soft_reset)
                    timer_flat[4*gi+3:4*gi] <= 4'h0;
                else if (bus_wr && bus_addr == `CCR_A_TMR0 + gi)
                    timer_flat[4*gi+3:4*gi] <= bus_wdata;
            end
        end
    endgenerate

    // Read decode
    always @*
    begin
        rd_value = 4'h0;
        case (bus_addr)
            `CCR_A_ACC: rd_value = acc;
            `CCR_A_BREG: rd_value = breg;
            `CCR_A_PAGE: rd_value = {2'b00, page};
            `CCR_A_COL: rd_value = col;
            `CCR_A_ROW: rd_value = row;
            `CCR_A_COL_X: rd_value = col_extra_reg;
            `CCR_A_ROW_X: rd_value = row_extra_reg;
            `CCR_A_FLAGS: rd_value = flags_rd;
            6'h08: rd_value = instruction_pointer[3:0];
            6'h09: rd_value = instruction_pointer[7:4];
            6'h0A: rd_value = instruction_pointer[11:8];
            6'h0B: rd_value = {2'b00, instruction_pointer[13:12]};
            6'h0C: rd_value = frame_pointer[3:0];
            6'h0D: rd_value = frame_pointer[7:4];
            6'h0E: rd_value = {2'b00, frame_pointer[9:8]};
            6'h20: rd_value = irq_req_flags[3:0];
            6'h21: rd_value = irq_req_flags[7:4];
            6'h22: rd_value = {1'b0, irq_req_flags[10:8]};
            `CCR_A_SERB: rd_value = {2'b00, serial_cfg_b_high, serial_cfg_b_low};
            6'h24: rd_value = prescaler_sys[3:0];
            6'h25: rd_value = prescaler_sys[7:4];
            6'h26: rd_value = {1'b0, prescaler_sys[10:8]};
            6'h27: rd_value = prescaler_w[3:0];
            6'h28: rd_value = prescaler_w[7:4];
            default:
            begin
                if (bus_addr >= `CCR_A_BANK0 && bus_addr < `CCR_A_IRQ0)
                    rd_value = bank[bus_addr[3:0]];
                else if (bus_addr >= `CCR_A_TMR0 && bus_addr < 6'h32)
                    rd_value = timer_flat[{bus_addr[2:0] - 3'h2, 2'b00} +: 4];
            end
        endcase
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            bus_rdata <= 4'h0;
        else if (bus_rd)
            bus_rdata <= rd_value;
        else
            bus_rdata <= 4'h0;
    end

endmodule // ccr_core

// >>> src/ccr_map.vh
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

// Register bus offsets
`define CCR_A_ACC 6'h00
`define CCR_A_BREG 6'h01
`define CCR_A_PAGE 6'h02
`define CCR_A_COL 6'h03
`define CCR_A_ROW 6'h04
`define CCR_A_COL_X 6'h05
`define CCR_A_ROW_X 6'h06
`define CCR_A_FLAGS 6'h07
`define CCR_A_IP0 6'h08
`define CCR_A_FP0 6'h0C
`define CCR_A_BANK0 6'h10
`define CCR_A_IRQ0 6'h20
`define CCR_A_SERB 6'h23
`define CCR_A_PSS0 6'h24
`define CCR_A_PSW0 6'h27
`define CCR_A_TMR0 6'h2A

// Flag field positions
`define CCR_F_OVF 0
`define CCR_F_COND 1

// Operation codes
`define CCR_OP_STEP 4'h0
`define CCR_OP_ARITH 4'h1
`define CCR_OP_COMPARE 4'h2
`define CCR_OP_BITTEST 4'h3
`define CCR_OP_JUMP 4'h4
`define CCR_OP_LJUMP 4'h5
`define CCR_OP_CALL 4'h6
`define CCR_OP_IRQ_ENTRY 4'h7
`define CCR_OP_PLAIN_RET 4'h8
`define CCR_OP_IRQ_RET 4'h9
`define CCR_OP_OVF_FORCE 4'hA
`define CCR_OP_OVF_DROP 4'hB
`define CCR_OP_SHL 4'hC
`define CCR_OP_SHR 4'hD
`define CCR_OP_BIT_CLEAR 4'hE
`define CCR_OP_EXCHANGE 4'hF

// Reset values, frame pointer top and step, and bank write mask
`define CCR_IP_RST 14'h0000
`define CCR_COND_RST 1'b1
`define CCR_FP_RST 10'h3FF
`define CCR_FP_TOP 4'hF
`define CCR_FP_STEP 6'h04
`define CCR_FP_LOW_RST 6'h3F
`define CCR_BANK_RST 64'h0000_0000_000F_7FF0
`define CCR_BANK_WMASK 64'hFFF7_F3FF_FFFF_7FF1
`define CCR_IRQ_RST 11'h000
`define CCR_SERB_LOW_RST 1'b0

`endif

// >>> src/ccr_flags.v
`timescale 1ns/100ps
`include "ccr_map.vh"

module ccr_flags
(
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    input wire soft_reset,
    // Operation
    input wire op_valid,
    input wire [3:0] op_code,
    input wire alu_carry,
    input wire test_result,
    input wire acc_msb,
    input wire acc_lsb,
    input wire pop_ovf,
    input wire pop_cond,
    // Bus write
    input wire wr_flags,
    input wire [1:0] wr_value,
    // Flags
    output reg overflow_bit,
    output reg condition_bit
);

    reg next_ovf;
    reg next_cond;

    always @*
    begin
        next_ovf = overflow_bit;
        next_cond = condition_bit;
        if (op_valid)
        begin
            case (op_code)
                `CCR_OP_ARITH:
                begin
                    next_ovf = alu_carry;
                    next_cond = test_result;
                end
                `CCR_OP_COMPARE, `CCR_OP_BITTEST:
                    next_cond = test_result;
                `CCR_OP_JUMP, `CCR_OP_LJUMP, `CCR_OP_CALL:
                    next_cond = 1'b1;
                `CCR_OP_IRQ_RET:
                begin
                    next_ovf = pop_ovf;
                    next_cond = pop_cond;
                end
                `CCR_OP_OVF_FORCE:
                    next_ovf = 1'b1;
                `CCR_OP_OVF_DROP:
                    next_ovf = 1'b0;
                `CCR_OP_SHL:
                    next_ovf = acc_msb;
                `CCR_OP_SHR:
                    next_ovf = acc_lsb;
                default:
                    next_ovf = overflow_bit;
            endcase
        end
        else if (wr_flags)
        begin
            next_ovf = wr_value[`CCR_F_OVF];
            next_cond = wr_value[`CCR_F_COND];
        end
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            overflow_bit <= 1'b0;
            condition_bit <= `CCR_COND_RST;
        end
        else if (soft_reset)
        begin
            overflow_bit <= 1'b0;
            condition_bit <= `CCR_COND_RST;
        end
        else
        begin
            overflow_bit <= next_ovf;
            condition_bit <= next_cond;
        end
    end

endmodule // ccr_flags

// >>> src/ccr_frame.v
`timescale 1ns/100ps
`include "ccr_map.vh"

module ccr_frame
(
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    input wire soft_reset,
    // Control
    input wire push,
    input wire pop,
    input wire reinit,
    // Pointer
    output wire [9:0] frame_pointer
);

    reg [5:0] fp_low;

    assign frame_pointer = {`CCR_FP_TOP, fp_low};

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            fp_low <= `CCR_FP_LOW_RST;
        else if (soft_reset || reinit)
            fp_low <= `CCR_FP_LOW_RST;
        else if (push)
            fp_low <= fp_low - `CCR_FP_STEP;
        else if (pop)
            fp_low <= fp_low + `CCR_FP_STEP;
    end

endmodule // ccr_frame

// >>> verif/ccr_core_props.sv
`timescale 1ns/100ps
`include "ccr_map.vh"
module ccr_props
(
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    input wire cpu_reset,
    // Operation
    input wire op_valid,
    input wire [3:0] op_code,
    input wire alu_carry,
    input wire [13:0] jump_target,
    input wire clear_reinit,
    input wire [13:0] pop_ip,
    input wire pop_ovf,
    input wire pop_cond,
    // Core state
    input wire push_strobe,
    input wire [9:0] push_addr,
    input wire fetch_en,
    input wire [13:0] instruction_pointer,
    input wire [9:0] frame_pointer,
    input wire overflow_bit,
    input wire condition_bit
);
default clocking cb @(posedge mclk);
endclocking
default disable iff (!reset_n);
wire go = op_valid && !cpu_reset;
wire [5:0] fp_lo = frame_pointer[5:0];
sequence s_enter;
    go && ((op_code == `CCR_OP_CALL && condition_bit) || op_code == `CCR_OP_IRQ_ENTRY);
endsequence
sequence s_pushed;
    push_strobe && push_addr == $past(frame_pointer) && fp_lo == $past(fp_lo) - 6'h04
        && instruction_pointer == $past(jump_target);
endsequence
a_reset_load: assert property (cpu_reset |=> instruction_pointer == 14'h0000 && condition_bit
    && frame_pointer == 10'h3FF && !fetch_en) else $error("reset state wrong");
a_fp_top: assert property (frame_pointer[9:6] == 4'hF) else $error("frame top bits");
a_enter_push: assert property (s_enter |=> s_pushed) else $error("frame push wrong");
a_plain_ret: assert property (go && op_code == `CCR_OP_PLAIN_RET |=> instruction_pointer ==
    $past(pop_ip) && fp_lo == $past(fp_lo) + 6'h04 && $stable(overflow_bit)
    && $stable(condition_bit)) else $error("plain return wrong");
a_irq_ret: assert property (go && op_code == `CCR_OP_IRQ_RET |=> overflow_bit == $past(pop_ovf)
    && condition_bit == $past(pop_cond)) else $error("irq return flags");
a_branch_cond: assert property (go && (op_code == `CCR_OP_JUMP || op_code == `CCR_OP_LJUMP
    || op_code == `CCR_OP_CALL) |=> condition_bit) else $error("branch cond");
a_step_hold: assert property (go && op_code == `CCR_OP_STEP |=> instruction_pointer ==
    $past(instruction_pointer) + 14'h0001 && $stable(condition_bit))
    else $error("step wrong");
a_ovf_ops: assert property (go && (op_code == `CCR_OP_OVF_FORCE || op_code == `CCR_OP_OVF_DROP)
    |=> overflow_bit == ($past(op_code) == `CCR_OP_OVF_FORCE)) else $error("ovf op");
a_arith_ovf: assert property (go && op_code == `CCR_OP_ARITH |=> overflow_bit ==
    $past(alu_carry)) else $error("arith ovf");
a_reinit_load: assert property (go && op_code == `CCR_OP_BIT_CLEAR && clear_reinit
    |=> frame_pointer == 10'h3FF) else $error("reinit");
a_fetch_start: assert property ($fell(cpu_reset) |-> !fetch_en ##1 fetch_en)
    else $error("fetch start");
endmodule // ccr_props
bind ccr_core ccr_props u_props (.mclk(mclk), .reset_n(reset_n), .cpu_reset(cpu_reset),
    .op_valid(op_valid), .op_code(op_code), .alu_carry(alu_carry), .jump_target(jump_target),
    .clear_reinit(clear_reinit), .pop_ip(pop_ip), .pop_ovf(pop_ovf), .pop_cond(pop_cond),
    .push_strobe(push_strobe), .push_addr(push_addr), .fetch_en(fetch_en),
    .instruction_pointer(instruction_pointer), .frame_pointer(frame_pointer),
    .overflow_bit(overflow_bit), .condition_bit(condition_bit));

// >>> verif/tb.sv
`timescale 1ns/100ps
`include "ccr_map.vh"
module tb;
reg mclk = 1'b0, reset_n = 1'b0, cpu_reset = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
reg op_valid = 1'b0, alu_carry = 1'b0, test_result = 1'b0, clear_reinit = 1'b0;
reg pop_ovf = 1'b0, pop_cond = 1'b0;
reg [5:0] bus_addr = 6'h00;
reg [3:0] bus_wdata = 4'h0, op_code = 4'h0, alu_result = 4'h7;
reg [13:0] jump_target = 14'h1234, pop_ip = 14'h0ABC, eip = 14'h0000;
reg [10:0] irq_event = 11'h000;
wire push_strobe, push_ovf, push_cond, fetch_en, overflow_bit, condition_bit, global_irq_gate;
wire [3:0] bus_rdata, acc, breg, col, row, port_out_latch, port_dir_ctrl, edge_pick_1;
wire [3:0] edge_pick_2;
wire [13:0] push_ip, instruction_pointer;
wire [9:0] push_addr, frame_pointer;
wire [10:0] irq_mask_bits, irq_req_flags;
wire [15:0] d_line_sel;
wire [1:0] page;
integer err_total = 0, checks = 0, cyc = 0;
always #20 mclk = ~mclk;
ccr_core dut (.mclk(mclk), .reset_n(reset_n), .cpu_reset(cpu_reset), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .op_valid(op_valid), .op_code(op_code), .alu_result(alu_result), .alu_carry(alu_carry),
    .test_result(test_result), .jump_target(jump_target), .clear_reinit(clear_reinit),
    .pop_ip(pop_ip), .pop_ovf(pop_ovf), .pop_cond(pop_cond), .irq_event(irq_event),
    .push_strobe(push_strobe), .push_addr(push_addr), .push_ip(push_ip), .push_ovf(push_ovf),
    .push_cond(push_cond), .fetch_en(fetch_en), .instruction_pointer(instruction_pointer),
    .frame_pointer(frame_pointer), .overflow_bit(overflow_bit), .condition_bit(condition_bit),
    .acc(acc), .breg(breg), .page(page), .col(col), .row(row), .d_line_sel(d_line_sel),
    .global_irq_gate(global_irq_gate), .irq_mask_bits(irq_mask_bits),
    .irq_req_flags(irq_req_flags), .port_out_latch(port_out_latch),
    .port_dir_ctrl(port_dir_ctrl), .edge_pick_1(edge_pick_1), .edge_pick_2(edge_pick_2));
task results;
begin
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
end
endtask
task chk(input string nm, input [15:0] exp, input [15:0] got);
begin
    checks = checks + 1;
    if (got !== exp)
    begin
        err_total = err_total + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
end
endtask
task wr(input [5:0] a, input [3:0] d);
begin
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge mclk);
    bus_wr <= 1'b0;
end
endtask
task rd(input [5:0] a, output [3:0] d);
begin
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
end
endtask
// One instruction; b feeds carry, reinit and saved overflow, t feeds test and saved condition
task op(input [3:0] c, input b, input t, input [13:0] e);
begin
    @(posedge mclk);
    op_valid <= 1'b1;
    op_code <= c;
    alu_carry <= b;
    clear_reinit <= b;
    pop_ovf <= b;
    test_result <= t;
    pop_cond <= t;
    @(posedge mclk);
    op_valid <= 1'b0;
    #1 chk("ip", e, instruction_pointer);
    eip = e;
end
endtask
task t_reset_vals;
    integer a;
    reg [3:0] e;
    reg [3:0] v;
begin
    for (a = 7; a < 64; a = a + 1)
    begin
        case (a)
            7: e = 4'h2;
            12, 13, 17, 18, 20: e = 4'hF;
            14: e = 4'h3;
            19: e = 4'h7;
            default: e = 4'h0;
        endcase
        // Prescalers run freely and are skipped
        if (a < 36 || a > 40)
        begin
            rd(a[5:0], v);
            if (a == 35)
                chk("serial b low", 1'b0, v[0]);
            else
                chk("reset reg", e, v);
        end
    end
    chk("masks", 16'h07FF, irq_mask_bits);
    chk("latch dir", 16'h00F0, {port_out_latch, port_dir_ctrl});
end
endtask
task t_cpu_reset;
    reg [3:0] v;
begin
    wr(6'h10, 4'h1);
    wr(6'h11, 4'h0);
    wr(6'h14, 4'h0);
    wr(6'h15, 4'hF);
    wr(6'h16, 4'h5);
    wr(6'h1F, 4'hA);
    @(posedge mclk);
    irq_event <= 11'h7FF;
    @(posedge mclk);
    irq_event <= 11'h000;
    rd(6'h20, v);
    chk("irq flags set", 4'hF, v);
    op(`CCR_OP_CALL, 1'b0, 1'b0, 14'h1234);
    @(posedge mclk);
    cpu_reset <= 1'b1;
    repeat (2) @(posedge mclk);
    cpu_reset <= 1'b0;
    #1 chk("fetch held", 1'b0, fetch_en);
    @(posedge mclk);
    #1 chk("fetch on", 1'b1, fetch_en);
    eip = 14'h0000;
    t_reset_vals;
end
endtask
task t_regs;
    integer a;
    reg [3:0] v;
begin
    for (a = 0; a < 7; a = a + 1)
        wr(a[5:0], 4'h9 + a[3:0]);
    for (a = 0; a < 7; a = a + 1)
    begin
        rd(a[5:0], v);
        chk("work reg", (a == 2) ? 4'h3 : 4'h9 + a[3:0], v);
    end
    chk("addr regs", 16'h3CD9, {page, col, row, acc});
    chk("d line", 16'h2000, d_line_sel);
    wr(6'h3F, 4'hF);
    op(`CCR_OP_EXCHANGE, 1'b0, 1'b0, eip + 14'h0001);
    @(posedge mclk);
    #1 chk("swap", 16'h00EF, {col, row});
    chk("d line swap", 16'h8000, d_line_sel);
    rd(6'h05, v);
    chk("col extra", 4'hC, v);
end
endtask
task t_flags;
begin
    op(`CCR_OP_OVF_FORCE, 1'b0, 1'b0, eip + 14'h0001);
    chk("ovf force", 1'b1, overflow_bit);
    op(`CCR_OP_OVF_DROP, 1'b0, 1'b0, eip + 14'h0001);
    chk("ovf drop", 1'b0, overflow_bit);
    op(`CCR_OP_SHL, 1'b0, 1'b0, eip + 14'h0001);
    chk("shl", 5'h12, {overflow_bit, acc});
    op(`CCR_OP_SHR, 1'b0, 1'b0, eip + 14'h0001);
    chk("shr", 5'h09, {overflow_bit, acc});
    op(`CCR_OP_ARITH, 1'b1, 1'b0, eip + 14'h0001);
    chk("arith", 6'h27, {overflow_bit, condition_bit, acc});
    op(`CCR_OP_STEP, 1'b0, 1'b1, eip + 14'h0001);
    chk("hold", 2'b10, {overflow_bit, condition_bit});
    op(`CCR_OP_ARITH, 1'b0, 1'b1, eip + 14'h0001);
    chk("arith clear", 2'b01, {overflow_bit, condition_bit});
    op(`CCR_OP_COMPARE, 1'b0, 1'b0, eip + 14'h0001);
    chk("compare", 1'b0, condition_bit);
    op(`CCR_OP_JUMP, 1'b0, 1'b0, eip + 14'h0001);
    chk("jump forced", 1'b1, condition_bit);
    op(`CCR_OP_BITTEST, 1'b0, 1'b0, eip + 14'h0001);
    op(`CCR_OP_LJUMP, 1'b0, 1'b0, eip + 14'h0001);
    chk("ljump forced", 1'b1, condition_bit);
    op(`CCR_OP_JUMP, 1'b0, 1'b0, 14'h1234);
end
endtask
task t_stack;
begin
    op(`CCR_OP_OVF_FORCE, 1'b0, 1'b0, eip + 14'h0001);
    op(`CCR_OP_CALL, 1'b0, 1'b0, 14'h1234);
    chk("push", 16'h1FFF, {push_strobe, push_ovf, push_cond, push_addr});
    chk("push ip", 16'h1236, push_ip);
    chk("fp call", 16'h03FB, frame_pointer);
    op(`CCR_OP_IRQ_RET, 1'b0, 1'b0, 14'h0ABC);
    chk("irq ret", 16'h03FF, {overflow_bit, condition_bit, frame_pointer});
    op(`CCR_OP_CALL, 1'b0, 1'b0, 14'h0ABD);
    chk("no call", 16'h07FF, {push_strobe, condition_bit, frame_pointer});
    op(`CCR_OP_IRQ_ENTRY, 1'b0, 1'b0, 14'h1234);
    chk("irq entry", 16'h03FB, frame_pointer);
    chk("irq push ip", 16'h0ABE, push_ip);
    op(`CCR_OP_PLAIN_RET, 1'b1, 1'b0, 14'h0ABC);
    chk("plain ret", 16'h07FF, {overflow_bit, condition_bit, frame_pointer});
    op(`CCR_OP_IRQ_ENTRY, 1'b0, 1'b0, 14'h1234);
    op(`CCR_OP_BIT_CLEAR, 1'b1, 1'b0, 14'h1235);
    chk("reinit", 16'h03FF, frame_pointer);
end
endtask
always @(posedge mclk)
begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
        err_total = err_total + 1;
        results;
    end
end
initial
begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1 chk("fetch first", 1'b1, fetch_en);
    t_reset_vals;
    t_cpu_reset;
    t_regs;
    t_flags;
    t_stack;
    results;
end
endmodule // tb
